// ---- rtl/mscb_defines.vh ----
`ifndef MSCB_DEFINES_VH
`define MSCB_DEFINES_VH
// ----------------------------------------------------------
// Register offsets
// ----------------------------------------------------------
`define MSCB_OFS_SAMPLE_DIV   8'h19
`define MSCB_OFS_ROT_FILTER   8'h1A
`define MSCB_OFS_ROT_SETUP    8'h1B
`define MSCB_OFS_ACC_SETUP    8'h1C
`define MSCB_OFS_ACC_EXT      8'h1D
`define MSCB_OFS_ROT_LP       8'h1E
`define MSCB_OFS_WAKE_X       8'h20
`define MSCB_OFS_WAKE_Y       8'h21
`define MSCB_OFS_IRQ_STATUS   8'h30
`define MSCB_OFS_IRQ_MASK     8'h31
// ----------------------------------------------------------
// Field positions
// ----------------------------------------------------------
`define MSCB_ST_X             7
`define MSCB_ST_Y             6
`define MSCB_ST_Z             5
`define MSCB_ROT_FS_HI        4
`define MSCB_ROT_FS_LO        2
`define MSCB_ROT_BYP_HI       1
`define MSCB_ROT_BYP_LO       0
`define MSCB_ACC_FS_HI        4
`define MSCB_ACC_FS_LO        3
`define MSCB_STAB_FS_HI       1
`define MSCB_STAB_FS_LO       0
`define MSCB_BUF_HI           7
`define MSCB_BUF_LO           6
`define MSCB_DEC_HI           5
`define MSCB_DEC_LO           4
`define MSCB_ACC_BYP          3
`define MSCB_LPF_HI           2
`define MSCB_LPF_LO           0
`define MSCB_LP_EN            7
`define MSCB_AVG_HI           6
`define MSCB_AVG_LO           4
`define MSCB_IRQ_SAMPLE       0
`define MSCB_IRQ_WAKE_X       1
`define MSCB_IRQ_WAKE_Y       2
// ----------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------
`define MSCB_MASK_ACC_SETUP   8'hFB
`define MSCB_MASK_ROT_LP      8'hF0
`define MSCB_MASK_ROT_FILTER  8'h07
`define MSCB_MASK_IRQ         8'h07
`define MSCB_RST_REG          8'h00
// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define MSCB_CLK_KHZ          250000
`define MSCB_ODR_1K_KHZ       1
`define MSCB_ODR_4K_KHZ       4
`define MSCB_ODR_8K_KHZ       8
`define MSCB_ODR_32K_KHZ      32
`endif

// ---- rtl/mscb_top.v ----
// Notes on behaviour
// - Rotation self-test enables from setup bits 7:5
// - Accel self-test enables from setup bits 7:5
// - Rotation range code picks full scale
// - Rotation bypass field selects 8800/3600 Hz
// - Main accel range code: 2,4,8,16 g
// - Stabilization accel range: 2,4,8,1 g
// - Buffer capacity field: 128 to 1024 bytes
// - Accel bypass gives 4 kHz, 1046 Hz
// - Accel lowpass table; value 7 fixed 1k
// - Divided rate is 1 kHz over 1+divider
// - Low-power accel averaging 1x or 4x-32x
// - Duty-cycle bit enables low-power rotation
// - Rotation averaging 1x to 128x, reset 000
// - Low-power rotation ignores lowpass setting
// - Separate 8-bit X and Y wake thresholds
`timescale 1ns/1ps
`include "mscb_defines.vh"

module mscb_top #(
  parameter CYC_1K  = `MSCB_CLK_KHZ / `MSCB_ODR_1K_KHZ,
  parameter CYC_4K  = `MSCB_CLK_KHZ / `MSCB_ODR_4K_KHZ,
  parameter CYC_8K  = `MSCB_CLK_KHZ / `MSCB_ODR_8K_KHZ,
  parameter CYC_32K = `MSCB_CLK_KHZ / `MSCB_ODR_32K_KHZ
) (
  input  wire        SYS_CLK,
  input  wire        NRST,
  input  wire [7:0]  ADDR,
  input  wire [7:0]  WDATA,
  input  wire        WR,
  input  wire        RD,
  output reg  [7:0]  RDATA,
  output wire        IRQ,
  input  wire        ACC_MAG_VALID,
  input  wire [7:0]  ACC_X_MAG,
  input  wire [7:0]  ACC_Y_MAG,
  output wire [2:0]  ROT_SELFTEST_EN,
  output wire [2:0]  ACC_SELFTEST_EN,
  output reg  [13:0] ROT_FS_EIGHTH_DPS,
  output reg         ROT_FS_VALID,
  output reg  [4:0]  ACC_FS_G,
  output reg  [4:0]  STAB_FS_G,
  output reg  [10:0] BUF_BYTES,
  output reg  [13:0] ROT_BW_HZ,
  output reg  [16:0] ACC_BW_CHZ,
  output reg  [2:0]  ACC_AVG_LOG2,
  output reg         ACC_AVG_VALID,
  output wire        ROT_LP_EN,
  output wire [2:0]  ROT_AVG_LOG2,
  output wire        ROT_SAMPLE,
  output wire        ACC_SAMPLE
);

  // --------------------------------------------------------
  // Reset release
  // --------------------------------------------------------
  reg        rst_s1_r;
  reg        rst_n_r;

  always @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // --------------------------------------------------------
  // Register file
  // --------------------------------------------------------
  reg  [7:0] sample_div_r;
  reg  [7:0] rot_filter_r;
  reg  [7:0] rot_setup_r;
  reg  [7:0] acc_setup_r;
  reg  [7:0] acc_ext_r;
  reg  [7:0] rot_lp_r;
  reg  [7:0] wake_x_r;
  reg  [7:0] wake_y_r;
  reg  [7:0] irq_status_r;
  reg  [7:0] irq_mask_r;
  reg  [7:0] irq_event;
  reg  [7:0] rdata_nxt;

  function sel;
    input [7:0] a;
    input [7:0] ofs;
    sel = (a == ofs);
  endfunction

  always @(posedge SYS_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      sample_div_r <= `MSCB_RST_REG;
      rot_filter_r <= `MSCB_RST_REG;
      rot_setup_r  <= `MSCB_RST_REG;
      acc_setup_r  <= `MSCB_RST_REG;
      acc_ext_r    <= `MSCB_RST_REG;
      rot_lp_r     <= `MSCB_RST_REG;
      wake_x_r     <= `MSCB_RST_REG;
      wake_y_r     <= `MSCB_RST_REG;
      irq_mask_r   <= `MSCB_RST_REG;
    end
    else if (WR)
    begin
      if (sel(ADDR, `MSCB_OFS_SAMPLE_DIV))
        sample_div_r <= WDATA;
      if (sel(ADDR, `MSCB_OFS_ROT_FILTER))
        rot_filter_r <= WDATA & `MSCB_MASK_ROT_FILTER;
      if (sel(ADDR, `MSCB_OFS_ROT_SETUP))
        rot_setup_r <= WDATA;
      if (sel(ADDR, `MSCB_OFS_ACC_SETUP))
        acc_setup_r <= WDATA & `MSCB_MASK_ACC_SETUP;
      if (sel(ADDR, `MSCB_OFS_ACC_EXT))
        acc_ext_r <= WDATA;
      if (sel(ADDR, `MSCB_OFS_ROT_LP))
        rot_lp_r <= WDATA & `MSCB_MASK_ROT_LP;
      if (sel(ADDR, `MSCB_OFS_WAKE_X))
        wake_x_r <= WDATA;
      if (sel(ADDR, `MSCB_OFS_WAKE_Y))
        wake_y_r <= WDATA;
      if (sel(ADDR, `MSCB_OFS_IRQ_MASK))
        irq_mask_r <= WDATA & `MSCB_MASK_IRQ;
    end
  end

  // Set beats clear so an event in the clearing cycle survives
  always @(posedge SYS_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      irq_status_r <= `MSCB_RST_REG;
    else if (WR && sel(ADDR, `MSCB_OFS_IRQ_STATUS))
      irq_status_r <= (irq_status_r & ~WDATA) | irq_event;
    else
      irq_status_r <= irq_status_r | irq_event;
  end

  assign IRQ = |(irq_status_r & irq_mask_r);

  // Unmapped reads return zero; data stands one cycle only
  always @*
  begin
    rdata_nxt = 8'h00;
    case (ADDR)
      `MSCB_OFS_SAMPLE_DIV: rdata_nxt = sample_div_r;
      `MSCB_OFS_ROT_FILTER: rdata_nxt = rot_filter_r;
      `MSCB_OFS_ROT_SETUP:  rdata_nxt = rot_setup_r;
      `MSCB_OFS_ACC_SETUP:  rdata_nxt = acc_setup_r;
      `MSCB_OFS_ACC_EXT:    rdata_nxt = acc_ext_r;
      `MSCB_OFS_ROT_LP:     rdata_nxt = rot_lp_r;
      `MSCB_OFS_WAKE_X:     rdata_nxt = wake_x_r;
      `MSCB_OFS_WAKE_Y:     rdata_nxt = wake_y_r;
      `MSCB_OFS_IRQ_STATUS: rdata_nxt = irq_status_r;
      `MSCB_OFS_IRQ_MASK:   rdata_nxt = irq_mask_r;
      default:              rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge SYS_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
      RDATA <= 8'h00;
    else if (RD)
      RDATA <= rdata_nxt;
    else
      RDATA <= 8'h00;
  end

  // --------------------------------------------------------
  // Field decode
  // --------------------------------------------------------
  wire [2:0] rot_range = rot_setup_r[`MSCB_ROT_FS_HI:`MSCB_ROT_FS_LO];
  wire [1:0] rot_byp   = rot_setup_r[`MSCB_ROT_BYP_HI:`MSCB_ROT_BYP_LO];
  wire [2:0] rot_lpf   = rot_filter_r[`MSCB_LPF_HI:`MSCB_LPF_LO];
  wire [1:0] acc_range = acc_setup_r[`MSCB_ACC_FS_HI:`MSCB_ACC_FS_LO];
  wire [1:0] stab_rng  = acc_setup_r[`MSCB_STAB_FS_HI:`MSCB_STAB_FS_LO];
  wire [1:0] buf_code  = acc_ext_r[`MSCB_BUF_HI:`MSCB_BUF_LO];
  wire [1:0] acc_dec   = acc_ext_r[`MSCB_DEC_HI:`MSCB_DEC_LO];
  wire       acc_byp   = acc_ext_r[`MSCB_ACC_BYP];
  wire [2:0] acc_lpf   = acc_ext_r[`MSCB_LPF_HI:`MSCB_LPF_LO];

  assign ROT_SELFTEST_EN = rot_setup_r[`MSCB_ST_X:`MSCB_ST_Z];
  assign ACC_SELFTEST_EN = acc_setup_r[`MSCB_ST_X:`MSCB_ST_Z];
  assign ROT_LP_EN       = rot_lp_r[`MSCB_LP_EN];
  assign ROT_AVG_LOG2    = rot_lp_r[`MSCB_AVG_HI:`MSCB_AVG_LO];

  always @(posedge SYS_CLK or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ROT_FS_EIGHTH_DPS <= 14'h0000;
      ROT_FS_VALID      <= 1'b0;
      ACC_FS_G          <= 5'h00;
      STAB_FS_G         <= 5'h00;
      BUF_BYTES         <= 11'h000;
      ROT_BW_HZ         <= 14'h0000;
      ACC_BW_CHZ        <= 17'h00000;
      ACC_AVG_LOG2      <= 3'h0;
      ACC_AVG_VALID     <= 1'b0;
    end
    else
    begin
      ROT_FS_VALID <= (rot_range != 3'h4);
      case (rot_range)
        3'h0:    ROT_FS_EIGHTH_DPS <= 14'h07D0;
        3'h1:    ROT_FS_EIGHTH_DPS <= 14'h0FA0;
        3'h2:    ROT_FS_EIGHTH_DPS <= 14'h1F40;
        3'h3:    ROT_FS_EIGHTH_DPS <= 14'h3E80;
        3'h5:    ROT_FS_EIGHTH_DPS <= 14'h00FA;
        3'h6:    ROT_FS_EIGHTH_DPS <= 14'h01F4;
        3'h7:    ROT_FS_EIGHTH_DPS <= 14'h03E8;
        default: ROT_FS_EIGHTH_DPS <= 14'h0000;
      endcase
      ACC_FS_G  <= 5'h02 << acc_range;
      STAB_FS_G <= (stab_rng == 2'h3) ? 5'h01
                                      : (5'h02 << stab_rng);
      BUF_BYTES <= 11'h080 << buf_code;
      // Zero bandwidth marks averaging-only filtering
      if (ROT_LP_EN)
        ROT_BW_HZ <= 14'h0000;
      else if (rot_byp[0])
        ROT_BW_HZ <= 14'h2260;
      else if (rot_byp[1])
        ROT_BW_HZ <= 14'h0E10;
      else
        case (rot_lpf)
          3'h0:    ROT_BW_HZ <= 14'h00FA;
          3'h1:    ROT_BW_HZ <= 14'h00B8;
          3'h2:    ROT_BW_HZ <= 14'h005C;
          3'h3:    ROT_BW_HZ <= 14'h0029;
          3'h4:    ROT_BW_HZ <= 14'h0014;
          3'h5:    ROT_BW_HZ <= 14'h000A;
          3'h6:    ROT_BW_HZ <= 14'h0005;
          default: ROT_BW_HZ <= 14'h0E10;
        endcase
      if (acc_byp)
        ACC_BW_CHZ <= 17'h19898;
      else
        case (acc_lpf)
          3'h0:    ACC_BW_CHZ <= 17'h05532;
          3'h1:    ACC_BW_CHZ <= 17'h05532;
          3'h2:    ACC_BW_CHZ <= 17'h026AC;
          3'h3:    ACC_BW_CHZ <= 17'h01180;
          3'h4:    ACC_BW_CHZ <= 17'h00848;
          3'h5:    ACC_BW_CHZ <= 17'h003FC;
          3'h6:    ACC_BW_CHZ <= 17'h001F9;
          default: ACC_BW_CHZ <= 17'h0A410;
        endcase
      // Other combinations have no defined averaging
      if (acc_byp && acc_dec == 2'h0)
      begin
        ACC_AVG_LOG2  <= 3'h0;
        ACC_AVG_VALID <= 1'b1;
      end
      else if (!acc_byp && acc_lpf == 3'h7)
      begin
        ACC_AVG_LOG2  <= {1'b0, acc_dec} + 3'h2;
        ACC_AVG_VALID <= 1'b1;
      end
      else
      begin
        ACC_AVG_LOG2  <= 3'h0;
        ACC_AVG_VALID <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------
  // Sample rate generation
  // --------------------------------------------------------
  // Rate codes: 0 = 1 kHz, 1 = 4 kHz, 2 = 8 kHz, 3 = 32 kHz
  function [17:0] period;
    input [1:0] code;
    case (code)
      2'h0:    period = CYC_1K[17:0];
      2'h1:    period = CYC_4K[17:0];
      2'h2:    period = CYC_8K[17:0];
      default: period = CYC_32K[17:0];
    endcase
  endfunction

  reg  [1:0] rate_code [0:1];
  reg        div_en    [0:1];
  wire [1:0] tick;

  always @*
  begin
    // Low-power rotation follows the divider at 1 kHz base
    rate_code[0] = 2'h0;
    div_en[0]    = 1'b1;
    if (!ROT_LP_EN && rot_byp != 2'h0)
    begin
      rate_code[0] = 2'h3;
      div_en[0]    = 1'b0;
    end
    else if (!ROT_LP_EN && (rot_lpf == 3'h0 || rot_lpf == 3'h7))
    begin
      rate_code[0] = 2'h2;
      div_en[0]    = 1'b0;
    end
    rate_code[1] = acc_byp ? 2'h1 : 2'h0;
    div_en[1]    = !acc_byp && (acc_lpf != 3'h7);
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_rate
      reg [17:0] cnt_r;
      reg [7:0]  dcnt_r;
      reg        tick_r;
      wire       base = (cnt_r >= period(rate_code[g]) - 18'h00001);

      // On rate change a counter past the new end restarts via the >= compare
      always @(posedge SYS_CLK or negedge rst_n_r)
      begin
        if (!rst_n_r)
        begin
          cnt_r     <= 18'h00000;
          dcnt_r    <= 8'h00;
          tick_r    <= 1'b0;
        end
        else
        begin
          cnt_r     <= base ? 18'h00000 : cnt_r + 18'h00001;
          tick_r    <= 1'b0;
          if (base)
          begin
            if (!div_en[g] || dcnt_r >= sample_div_r)
            begin
              dcnt_r    <= 8'h00;
              tick_r    <= 1'b1;
            end
            else
              dcnt_r <= dcnt_r + 8'h01;
          end
        end
      end
      assign tick[g] = tick_r;
    end
  endgenerate

  assign ROT_SAMPLE = tick[0];
  assign ACC_SAMPLE = tick[1];

  // --------------------------------------------------------
  // Events
  // --------------------------------------------------------
  always @*
  begin
    irq_event = 8'h00;
    irq_event[`MSCB_IRQ_SAMPLE] = tick[1];
    irq_event[`MSCB_IRQ_WAKE_X] = ACC_MAG_VALID &&
                                  (ACC_X_MAG > wake_x_r);
    irq_event[`MSCB_IRQ_WAKE_Y] = ACC_MAG_VALID &&
                                  (ACC_Y_MAG > wake_y_r);
  end

endmodule // mscb_top

// ---- sim/mscb_checker.sv ----
`timescale 1ns/1ps
module mscb_checker #(
  parameter CYC_1K  = 40,
  parameter CYC_4K  = 10,
  parameter CYC_8K  = 5,
  parameter CYC_32K = 2
) (
  input wire        SYS_CLK,
  input wire        NRST,
  input wire [7:0]  ADDR,
  input wire [7:0]  WDATA,
  input wire        WR,
  input wire        RD,
  input wire [7:0]  RDATA,
  input wire        IRQ,
  input wire [2:0]  ROT_SELFTEST_EN,
  input wire [2:0]  ACC_SELFTEST_EN,
  input wire        ROT_FS_VALID,
  input wire [4:0]  ACC_FS_G,
  input wire [4:0]  STAB_FS_G,
  input wire [10:0] BUF_BYTES,
  input wire        ROT_LP_EN,
  input wire [2:0]  ROT_AVG_LOG2,
  input wire        ACC_SAMPLE
);
  wire       wr_rot = WR && ADDR == 8'h1B;
  wire       wr_acc = WR && ADDR == 8'h1C;
  wire       wr_ext = WR && ADDR == 8'h1D;
  wire       wr_lp  = WR && ADDR == 8'h1E;
  wire [2:0] wd_hi  = WDATA[7:5];
  wire [2:0] wd_mid = WDATA[4:2];
  wire [1:0] wd_afs = WDATA[4:3];
  wire [1:0] wd_lo  = WDATA[1:0];
  wire [3:0] wd_lp  = WDATA[7:4];
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  chk_rot_selftest: assert property (
    wr_rot |=> ROT_SELFTEST_EN == $past(wd_hi)) else $error("rot st");
  chk_acc_selftest: assert property (
    wr_acc |=> ACC_SELFTEST_EN == $past(wd_hi)) else $error("acc st");
  chk_rot_valid: assert property (
    wr_rot |-> ##2 ROT_FS_VALID == ($past(wd_mid, 2) != 3'h4))
    else $error("rot range valid");
  chk_acc_range: assert property (
    wr_acc |-> ##2 ACC_FS_G == (5'h02 << $past(wd_afs, 2)))
    else $error("acc range");
  chk_stab_range: assert property (
    wr_acc |-> ##2 STAB_FS_G == ((&$past(wd_lo, 2)) ? 5'h01 :
      (5'h02 << $past(wd_lo, 2)))) else $error("stab range");
  chk_buf_size: assert property (
    wr_ext |-> ##2 BUF_BYTES == (11'h080 << $past(WDATA[7:6], 2)))
    else $error("buffer size");
  chk_lp_fields: assert property (
    wr_lp |=> {ROT_LP_EN, ROT_AVG_LOG2} == $past(wd_lp))
    else $error("low-power fields");
  chk_resv_zero: assert property (
    RD && ADDR == 8'h1E |=> RDATA[3:0] == 4'h0) else $error("reserved");
  // Checks eight quiet cycles after each accel sample; the fastest accel rate leaves nine
  chk_acc_spacing: assert property (
    ACC_SAMPLE |=> !ACC_SAMPLE [*8]) else $error("acc sample spacing");
  cp_read: cover property (RD);
  cp_irq: cover property ($rose(IRQ));
  cp_acc_tick: cover property (ACC_SAMPLE);
endmodule // mscb_checker

bind mscb_top mscb_checker #(
  .CYC_1K(CYC_1K), .CYC_4K(CYC_4K), .CYC_8K(CYC_8K), .CYC_32K(CYC_32K)
) chk_u (
  .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .ROT_SELFTEST_EN(ROT_SELFTEST_EN),
  .ACC_SELFTEST_EN(ACC_SELFTEST_EN), .ROT_FS_VALID(ROT_FS_VALID),
  .ACC_FS_G(ACC_FS_G), .STAB_FS_G(STAB_FS_G), .BUF_BYTES(BUF_BYTES),
  .ROT_LP_EN(ROT_LP_EN), .ROT_AVG_LOG2(ROT_AVG_LOG2),
  .ACC_SAMPLE(ACC_SAMPLE)
);

// ---- sim/mscb_mag_src.sv ----
`timescale 1ns/1ps
module mscb_mag_src (
  input  wire       clk,
  output reg        valid,
  output reg  [7:0] mag_x,
  output reg  [7:0] mag_y
);
  initial
  begin
    valid = 1'b0;
    mag_x = 8'h00;
    mag_y = 8'h00;
  end
  // Stale magnitudes are inverted so a late sample cannot match
  task send(input [7:0] x, input [7:0] y);
  begin
    @(posedge clk);
    valid <= 1'b1;
    mag_x <= x;
    mag_y <= y;
    @(posedge clk);
    valid <= 1'b0;
    mag_x <= ~x;
    mag_y <= ~y;
  end
  endtask
endmodule // mscb_mag_src

// ---- sim/mscb_top_tb.sv ----
`timescale 1ns/1ps
module mscb_top_tb;
  reg         SYS_CLK = 1'b0;
  reg         NRST    = 1'b0;
  reg  [7:0]  ADDR    = 8'h00;
  reg  [7:0]  WDATA   = 8'h00;
  reg         WR      = 1'b0;
  reg         RD      = 1'b0;
  wire [7:0]  RDATA, MAG_X, MAG_Y;
  wire        IRQ, ROT_FS_VALID, ACC_AVG_VALID, ROT_LP_EN, MAG_VALID;
  wire        ROT_SAMPLE, ACC_SAMPLE;
  wire [2:0]  ROT_ST, ACC_ST, ACC_AVG_LOG2, ROT_AVG_LOG2;
  wire [13:0] ROT_FS, ROT_BW_HZ;
  wire [4:0]  ACC_FS_G, STAB_FS_G;
  wire [10:0] BUF_BYTES;
  wire [16:0] ACC_BW_CHZ;
  wire [3:0]  ACC_AVG = {ACC_AVG_VALID, ACC_AVG_LOG2};
  integer     failures  = 0;
  integer     cmp_count = 0;
  integer     i;
  integer     acc_bw [0:7] = '{21810, 21810, 9900, 4480, 2120, 1020, 505,
                               42000};

  always #2 SYS_CLK = ~SYS_CLK;

  mscb_top #(.CYC_1K(40), .CYC_4K(10), .CYC_8K(5), .CYC_32K(2)) dut_u (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .ACC_MAG_VALID(MAG_VALID),
    .ACC_X_MAG(MAG_X), .ACC_Y_MAG(MAG_Y), .ROT_SELFTEST_EN(ROT_ST),
    .ACC_SELFTEST_EN(ACC_ST), .ROT_FS_EIGHTH_DPS(ROT_FS),
    .ROT_FS_VALID(ROT_FS_VALID), .ACC_FS_G(ACC_FS_G), .STAB_FS_G(STAB_FS_G),
    .BUF_BYTES(BUF_BYTES), .ROT_BW_HZ(ROT_BW_HZ), .ACC_BW_CHZ(ACC_BW_CHZ),
    .ACC_AVG_LOG2(ACC_AVG_LOG2), .ACC_AVG_VALID(ACC_AVG_VALID),
    .ROT_LP_EN(ROT_LP_EN), .ROT_AVG_LOG2(ROT_AVG_LOG2),
    .ROT_SAMPLE(ROT_SAMPLE), .ACC_SAMPLE(ACC_SAMPLE)
  );
  mscb_mag_src mag_u (.clk(SYS_CLK), .valid(MAG_VALID), .mag_x(MAG_X),
    .mag_y(MAG_Y));

  // ----------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------
  task cmp(input string what, input [16:0] exp, input [16:0] got);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("wrong value %0s: expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task tick;
  begin
    @(posedge SYS_CLK);
    #1;
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge SYS_CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge SYS_CLK);
    WR <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] exp);
  begin
    @(posedge SYS_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1;
    cmp("rdata", exp, RDATA & m);
  end
  endtask
  // First pulses after a rate change may be short, so skip two
  task period(input rot, input integer exp);
    integer n;
  begin
    repeat (3)
    begin
      n = 1;
      tick;
      while ((rot ? ROT_SAMPLE : ACC_SAMPLE) !== 1'b1 && n < 500)
      begin
        tick;
        n = n + 1;
      end
    end
    cmp("sample period", exp, n);
  end
  endtask
  task do_reset;
  begin
    NRST <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    repeat (3) tick;
  end
  endtask
  task print_verdict;
  begin
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask

  initial
  begin
    #100000;
    failures = failures + 1;
    print_verdict;
  end

  // ----------------------------------------------------------
  // Tests
  // ----------------------------------------------------------
  initial
  begin
    do_reset;
    rd(8'h1E, 8'hFF, 8'h00);
    cmp("rot fs", 2000, ROT_FS);
    cmp("buf", 128, BUF_BYTES);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h1B, {3'b101, i[2:0], 2'b00});
      tick;
      cmp("rot valid", i != 4, ROT_FS_VALID);
      if (i != 4)
        cmp("rot fs", i < 4 ? 2000 << i : 250 << (i - 5), ROT_FS);
      cmp("rot st", 3'b101, ROT_ST);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h1C, {3'b011, i[1:0], 1'b1, i[1:0]});
      tick;
      cmp("acc fs", 2 << i, ACC_FS_G);
      cmp("stab fs", i == 3 ? 1 : 2 << i, STAB_FS_G);
      cmp("acc st", 3'b011, ACC_ST);
      rd(8'h1C, 8'hFF, {3'b011, i[1:0], 1'b0, i[1:0]});
      wr(8'h1D, {i[1:0], 6'h08});
      tick;
      cmp("buf", 128 << i, BUF_BYTES);
      cmp("acc bw", 104600, ACC_BW_CHZ);
      cmp("acc avg", 8, ACC_AVG);
    end
    $display("test ranges ended");
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h1D, {2'b00, i[1:0], 1'b0, i[2:0]});
      tick;
      cmp("acc bw", acc_bw[i], ACC_BW_CHZ);
      cmp("acc avg", i == 7 ? 13 : 0, ACC_AVG);
    end
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(8'h1D, {2'b00, i[1:0], 4'h7});
      tick;
      cmp("acc avg", 10 + i, ACC_AVG);
    end
    wr(8'h1D, 8'h08);
    period(1'b0, 10);
    wr(8'h19, 8'h02);
    wr(8'h1D, 8'h01);
    period(1'b0, 120);
    for (i = 1; i < 4; i = i + 1)
    begin
      wr(8'h1B, {6'h00, i[1:0]});
      tick;
      cmp("rot bw", i == 2 ? 3600 : 8800, ROT_BW_HZ);
    end
    period(1'b1, 2);
    $display("test filters ended");
    wr(8'h1A, 8'h03);
    wr(8'h1E, 8'h80);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'h1E, {1'b1, i[2:0], 4'hF});
      tick;
      cmp("lp", 8 + i, {ROT_LP_EN, ROT_AVG_LOG2});
      cmp("rot bw", 0, ROT_BW_HZ);
      rd(8'h1E, 8'hFF, {1'b1, i[2:0], 4'h0});
    end
    period(1'b1, 120);
    wr(8'h1E, 8'h00);
    wr(8'h1B, 8'h00);
    tick;
    cmp("rot bw", 41, ROT_BW_HZ);
    period(1'b1, 120);
    wr(8'h1A, 8'h00);
    tick;
    cmp("rot bw", 250, ROT_BW_HZ);
    period(1'b1, 5);
    $display("test low power ended");
    wr(8'h20, 8'hA5);
    wr(8'h21, 8'h5A);
    rd(8'h20, 8'hFF, 8'hA5);
    rd(8'h21, 8'hFF, 8'h5A);
    rd(8'h30, 8'h01, 8'h01);
    wr(8'h31, 8'h06);
    mag_u.send(8'hA5, 8'h5B);
    repeat (2) tick;
    cmp("irq", 1, IRQ);
    rd(8'h30, 8'h06, 8'h04);
    wr(8'h30, 8'h06);
    tick;
    cmp("irq", 0, IRQ);
    wr(8'h31, 8'h00);
    mag_u.send(8'hA6, 8'h00);
    repeat (2) tick;
    cmp("irq", 0, IRQ);
    rd(8'h30, 8'h06, 8'h02);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'hFF, 8'h00);
    $display("test wake ended");
    do_reset;
    rd(8'h21, 8'hFF, 8'h00);
    rd(8'h1E, 8'hFF, 8'h00);
    $display("test reset ended");
    print_verdict;
  end
endmodule // mscb_top_tb
